// ### hdl/cidt_pkg.sv
// package for the instruction decode and cycle-timing block
// Functional notes
// - instruction words are 14 bits and carry opcode and all operands with no extension words.
// - every opcode is sorted into byte-oriented, bit-oriented or literal/control class.
// - an instruction that is not an exception completes in one instruction cycle.
// - both subroutine calls, literal target and via accumulator, take two cycles.
// - plain return, return with literal and return from interrupt take two cycles.
// - absolute jump, relative branch, branch via accumulator and taken skips take two cycles.
// - an indirect access while the selected pointer addresses program memory adds one cycle.
// - one instruction cycle is four oscillator cycles.
// - every instruction naming a file register reads it first, then writes the result.
// - destination bit 0 sends the result to the accumulator, 1 back to the file register.
// - the file address field selects a register 0x00 to 0x7F of the current bank.
// - the bit address field picks one of eight bit positions of the file register.
// - the pointer number field selects pointer 0 or 1 and its indirect access register.
// - a two-bit mode field selects pre-increment, pre-decrement, post-increment or post-decrement.
// - don't-care bits are ignored, the result is the same whether they are 0 or 1.
package cidt_pkg;
   localparam int          INSN_W      = 14;
   localparam int          PHASES      = 4;
   localparam logic [1:0]  PHASE_LAST  = 2'h3;
   localparam logic [6:0]  INDIRECT0   = 7'h00;
   localparam logic [6:0]  INDIRECT1   = 7'h01;
   localparam logic [13:0] NOP_WORD    = 14'h0000;

   typedef enum logic [1:0] {CIDT_BYTE, CIDT_BIT, CIDT_LITCTL} cidt_class_t;
   typedef enum logic [1:0] {CIDT_PREINC, CIDT_PREDEC, CIDT_POSTINC, CIDT_POSTDEC} cidt_mode_t;

   // decoded operand fields of one word
   typedef struct packed {
      cidt_class_t cls;
      logic [6:0]  file_addr;
      logic        dest_file;
      logic [2:0]  bit_addr;
      logic [7:0]  literal;
      logic        ptr_num;
      cidt_mode_t  ptr_mode;
      logic        uses_file;
      logic        is_ptr;
   } cidt_fields_t;

   // per-instruction cycle figures
   typedef struct packed {
      logic       flow_change;
      logic       cond_skip;
      logic       indirect;
   } cidt_timing_t;
endpackage

// ### hdl/cidt_decoder.sv
// instruction decode, read-modify-write sequencing and cycle timing of the core
`timescale 1ns/100ps
module cidt_decoder
   import cidt_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic [INSN_W-1:0] i_insn,          // prefetched word, valid at end of cycle
   input  wire logic              i_skip_cond,     // bit test or count-to-zero result from datapath
   input  wire logic              i_ptr0_prog,     // pointer 0 addresses program memory
   input  wire logic              i_ptr1_prog,     // pointer 1 addresses program memory
   output logic                   o_fetch,         // pulse: take the next word
   output logic [1:0]             o_phase,
   output cidt_fields_t           o_fields,
   output logic                   o_file_read,     // pulse in phase 1
   output logic                   o_file_write,    // pulse in phase 3
   output logic                   o_acc_write,     // pulse in phase 3
   output logic                   o_nop_cycle,     // level over a discarded cycle
   output logic                   o_extra_cycle    // level over an indirect stall cycle
);

   typedef enum logic [1:0] {CIDT_EXEC, CIDT_FLUSH, CIDT_STALL} cidt_state_t;

   // split a word into class and operand fields
   function automatic cidt_fields_t decode(input logic [INSN_W-1:0] w);
      cidt_fields_t f;
      f = '0;
      f.file_addr = w[6:0];
      f.dest_file = w[7];
      f.bit_addr  = w[9:7];
      f.literal   = w[7:0];
      f.ptr_num   = w[2];
      f.ptr_mode  = cidt_mode_t'(w[1:0]);
      unique case (w[13:12])
         2'h0: begin
            f.cls = CIDT_BYTE;
            f.uses_file = (w[11:8] != 4'h0) || w[7];                   // movwf and above name a file
         end
         2'h1: begin
            f.cls = CIDT_BIT;
            f.uses_file = 1'b1;
         end
         default: begin
            f.cls = CIDT_LITCTL;
            f.uses_file = 1'b0;
         end
      endcase
      f.is_ptr = (w[13:3] == 11'h002);                                 // pointer update group
      return f;
   endfunction

   // cycle-count class of a word; don't-care bits of a no-operation word reach the indirect test
   function automatic cidt_timing_t timing(input logic [INSN_W-1:0] w);
      cidt_timing_t t;
      t = '0;
      t.flow_change = (w[13:12] == 2'h2)                               // call and absolute_jump
                    || (w[13:9] == 5'h19)                              // relative_branch
                    || (w == 14'h0008) || (w == 14'h0009)              // return, return_from_interrupt
                    || (w[13:8] == 6'h34)                              // return_with_literal
                    || (w == 14'h000A) || (w == 14'h000B);             // call/branch via accumulator
      t.cond_skip   = (w[13:11] == 3'h3)                               // skip_if_bit_clear / set
                    || (w[13:8] == 6'h0B) || (w[13:8] == 6'h0F);        // decrement/increment skip
      t.indirect    = ((w[13:12] == 2'h0) || (w[13:12] == 2'h1))
                    && ((w[6:0] == INDIRECT0) || (w[6:0] == INDIRECT1));
      return t;
   endfunction

   logic [1:0]        phase_reg, phase_next;
   cidt_state_t       state_reg, state_next;
   logic [INSN_W-1:0] ir_reg, ir_next;
   cidt_fields_t      fields_reg, fields_next;
   logic              fetch_reg, fetch_next;
   logic              rd_reg, rd_next, wf_reg, wf_next, wa_reg, wa_next;
   logic              nop_reg, nop_next, stall_reg, stall_next;
   cidt_fields_t      cur_f;
   cidt_timing_t      cur_t;
   logic              ptr_prog;
   logic              end_cycle;
   logic              stall_hit;
   logic              flow_hit;

   assign cur_f     = decode(ir_reg);
   assign cur_t     = timing(ir_reg);
   assign end_cycle = (phase_reg == PHASE_LAST);
   assign ptr_prog  = ir_reg[0] ? i_ptr1_prog : i_ptr0_prog;           // pointer behind the indirect register
   // a word that names no file (no-operation, pointer group) never stalls on the pointer
   assign stall_hit = cur_t.indirect && cur_f.uses_file && ptr_prog;
   assign flow_hit  = cur_t.flow_change || (cur_t.cond_skip && i_skip_cond);

   // phase counter, sequencing state and per-phase strobes
   always_comb begin
      phase_next  = phase_reg + 2'h1;
      state_next  = state_reg;
      ir_next     = ir_reg;
      fields_next = cur_f;
      fetch_next  = 1'b0;
      rd_next     = 1'b0;
      wf_next     = 1'b0;
      wa_next     = 1'b0;
      nop_next    = nop_reg;
      stall_next  = stall_reg;
      if (state_reg == CIDT_EXEC) begin
         rd_next = (phase_reg == 2'h0) && cur_f.uses_file;             // read before every write
         wf_next = (phase_reg == 2'h2) && cur_f.uses_file
                 && (cur_f.cls == CIDT_BIT || cur_f.dest_file);
         wa_next = (phase_reg == 2'h2) && cur_f.cls == CIDT_BYTE
                 && !cur_f.dest_file && cur_f.uses_file;
      end
      if (end_cycle) begin
         unique case (state_reg)
            CIDT_EXEC: begin
               if (stall_hit) begin
                  state_next = CIDT_STALL;
                  stall_next = 1'b1;
               end else if (flow_hit) begin
                  state_next = CIDT_FLUSH;
                  ir_next    = NOP_WORD;
                  nop_next   = 1'b1;
                  fetch_next = 1'b1;
               end else begin
                  ir_next    = i_insn;
                  fetch_next = 1'b1;
               end
            end
            CIDT_STALL: begin
               stall_next = 1'b0;
               fetch_next = 1'b1;
               if (flow_hit) begin
                  state_next = CIDT_FLUSH;                             // stall first, then the flush
                  ir_next    = NOP_WORD;
                  nop_next   = 1'b1;
               end else begin
                  state_next = CIDT_EXEC;
                  ir_next    = i_insn;
               end
            end
            CIDT_FLUSH: begin
               state_next = CIDT_EXEC;
               nop_next   = 1'b0;
               ir_next    = i_insn;
               fetch_next = 1'b1;
            end
            default: state_next = CIDT_EXEC;
         endcase
      end
   end

   // registers only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_reg  <= 2'h0;
         state_reg  <= CIDT_FLUSH;
         ir_reg     <= NOP_WORD;
         fields_reg <= '0;
         fetch_reg  <= 1'b0;
         rd_reg     <= 1'b0;
         wf_reg     <= 1'b0;
         wa_reg     <= 1'b0;
         nop_reg    <= 1'b1;
         stall_reg  <= 1'b0;
      end else begin
         phase_reg  <= phase_next;
         state_reg  <= state_next;
         ir_reg     <= ir_next;
         fields_reg <= fields_next;
         fetch_reg  <= fetch_next;
         rd_reg     <= rd_next;
         wf_reg     <= wf_next;
         wa_reg     <= wa_next;
         nop_reg    <= nop_next;
         stall_reg  <= stall_next;
      end
   end

   assign o_phase       = phase_reg;
   assign o_fields      = fields_reg;
   assign o_fetch       = fetch_reg;
   assign o_file_read   = rd_reg;
   assign o_file_write  = wf_reg;
   assign o_acc_write   = wa_reg;
   assign o_nop_cycle   = nop_reg;
   assign o_extra_cycle = stall_reg;

   // instruction cycles are exactly four clocks apart
   fetch_spacing_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_fetch |=> !o_fetch [*3] ##1 (o_fetch || o_extra_cycle))
      else $error("fetch spacing wrong");
   phase_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_phase == 2'h3) |=> (o_phase == 2'h0) ##3 (o_phase == 2'h3))
      else $error("phase does not wrap every four clocks");
   read_before_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_file_write |-> $past(o_file_read, 2))
      else $error("file written without prior read");
   dest_route_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !(o_file_write && o_acc_write))
      else $error("result routed to both destinations");
   flush_nop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_nop_cycle) |-> !o_file_read [*4])
      else $error("discarded cycle touched a file");
   flush_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_nop_cycle) |-> o_nop_cycle [*4] ##1 !o_nop_cycle)
      else $error("flush cycle not one instruction cycle");
   stall_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_extra_cycle) |-> o_extra_cycle [*4] ##1 !o_extra_cycle)
      else $error("indirect stall not one instruction cycle");
   stall_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_extra_cycle |-> !o_file_write && !o_acc_write)
      else $error("write during indirect stall");
   phase_strobe_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_file_read |-> o_phase == 2'h1)
      else $error("file read outside phase 1");
   fetch_phase_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_fetch |-> o_phase == 2'h0)
      else $error("fetch outside phase 0");
   write_phase_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_file_write || o_acc_write) |-> o_phase == 2'h3)
      else $error("write outside phase 3");
   stall_entry_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (end_cycle && state_reg == CIDT_EXEC && stall_hit) |=> o_extra_cycle && !o_fetch)
      else $error("indirect access did not stall");
   flow_flush_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (end_cycle && state_reg == CIDT_EXEC && flow_hit && !stall_hit) |=> o_nop_cycle && o_fetch)
      else $error("flow change did not insert a discarded cycle");
   single_cycle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (end_cycle && state_reg == CIDT_EXEC && !stall_hit && !flow_hit)
         |=> o_fetch && !o_nop_cycle && !o_extra_cycle)
      else $error("plain instruction took more than one cycle");
   nop_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_nop_cycle |-> !o_file_write && !o_acc_write)
      else $error("write during discarded cycle");
endmodule

// ### sim/cidt_decoder_tb.sv
// self-checking bench for the instruction decoder and cycle timing
`timescale 1ns/100ps
module cidt_decoder_tb;
   import cidt_pkg::*;
   // note: flags {stray,read,fwrite,awrite,nop,extra}, flag care mask, fields, field mask
   typedef struct packed {logic [5:0] fl; logic [5:0] fc; cidt_fields_t f; cidt_fields_t fm;} cidt_note_t;
   logic         i_clk = 1'b0, i_rst_n = 1'b0, i_skip_cond = 1'b0, i_ptr0_prog = 1'b0, i_ptr1_prog = 1'b0;
   logic [13:0]  i_insn = NOP_WORD, w;
   logic         o_fetch, o_file_read, o_file_write, o_acc_write, o_nop_cycle, o_extra_cycle;
   logic [1:0]   o_phase, ph_prev;
   cidt_fields_t o_fields, fo, mb, mt, ml, mp;
   int           n_mismatch = 0, n_tests = 0;
   cidt_note_t   q[$], nn;
   logic [5:0]   obs;
   logic         armed = 1'b0;
   logic [7:0]   rnd = 8'h47;
   logic [13:0]  tc[8] = '{14'h2123, 14'h2ABC, 14'h0008, 14'h0009, 14'h000A, 14'h000B, 14'h3455, 14'h3201};
   logic [13:0]  sk[4] = '{14'h1D33, 14'h1933, 14'h0BA5, 14'h0FA5};

   cidt_decoder dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_insn(i_insn), .i_skip_cond(i_skip_cond),
      .i_ptr0_prog(i_ptr0_prog), .i_ptr1_prog(i_ptr1_prog), .o_fetch(o_fetch), .o_phase(o_phase),
      .o_fields(o_fields), .o_file_read(o_file_read), .o_file_write(o_file_write),
      .o_acc_write(o_acc_write), .o_nop_cycle(o_nop_cycle), .o_extra_cycle(o_extra_cycle));

   // 200 MHz clock
   always #2.5 i_clk = ~i_clk;

   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // expected fields; pt is {is_ptr, ptr_num, mode}
   function automatic cidt_fields_t fv(input logic [1:0] c, input logic [6:0] fa, input logic d,
                                       input logic [2:0] b, input logic [7:0] k, input logic [3:0] pt);
      fv = '0;
      fv.cls = cidt_class_t'(c);
      fv.file_addr = fa;
      fv.dest_file = d;
      fv.bit_addr = b;
      fv.literal = k;
      fv.is_ptr = pt[3];
      fv.ptr_num = pt[2];
      fv.ptr_mode = cidt_mode_t'(pt[1:0]);
   endfunction

   // hold a word until the edge that ends phase 3 takes it
   task automatic present(input logic [13:0] wd);
      i_insn <= wd;
      do @(negedge i_clk); while (o_phase !== PHASE_LAST);
      @(posedge i_clk);
   endtask

   // issue a word; fk 1 adds a flushed cycle, 2 a stall cycle, both then re-present a plain word
   task automatic issue(input logic [13:0] wd, input logic [2:0] sp, input logic [5:0] fl, fc,
                        input cidt_fields_t f, fm, input int fk);
      q.push_back('{fl, fc, f, fm});
      present(wd);
      // conditions belong to the word now executing and are sampled at its last phase
      i_skip_cond <= sp[2];
      i_ptr0_prog <= sp[1];
      i_ptr1_prog <= sp[0];
      if (fk != 0) begin
         q.push_back('{(fk == 1) ? 6'h02 : 6'h01, 6'h23, '0, '0});
         present(NOP_WORD);
         q.push_back('{6'h00, 6'h3F, '0, '0});
         present(NOP_WORD);
      end
   endtask

   // monitor: gather one instruction cycle and settle it against the oldest note
   always @(negedge i_clk) begin
      if (armed) check("phase", o_phase, 2'(ph_prev + 2'h1));
      ph_prev = o_phase;
      if (i_rst_n && o_phase === 2'h0) armed = 1'b1;
      if (o_phase === 2'h0) obs = '0;
      obs[5] |= (o_fetch && o_phase !== 2'h0) || (o_file_read && o_phase !== 2'h1)
                || ((o_file_write || o_acc_write) && o_phase !== PHASE_LAST);
      obs[4:2] |= {o_file_read, o_file_write, o_acc_write};
      if (o_phase === 2'h2) begin
         obs[1:0] = {o_nop_cycle, o_extra_cycle};
         fo = o_fields;
      end
      if (armed && o_phase === PHASE_LAST && q.size() > 0) begin
         nn = q.pop_front();
         check("flags", obs & nn.fc, nn.fl & nn.fc);
         check("fields", fo & nn.fm, nn.f & nn.fm);
      end
   end

   // watchdog: the sequence needs about 320 clocks
   initial begin
      #20000;
      n_mismatch++;
      finish_test();
   end

   initial begin
      mb = fv(2'h3, 7'h7F, 1'b1, 3'h0, 8'h00, 4'h0);
      mt = fv(2'h3, 7'h7F, 1'b0, 3'h7, 8'h00, 4'h0);
      ml = fv(2'h3, 7'h00, 1'b0, 3'h0, 8'hFF, 4'h0);
      mp = fv(2'h0, 7'h00, 1'b0, 3'h0, 8'h00, 4'hF);
      q.push_back('{6'h02, 6'h3F, '0, '0}); // first cycle after reset is discarded
      repeat (8) @(posedge i_clk);
      i_rst_n <= 1'b1;
      issue(14'h077F, 3'h0, 6'h14, 6'h3F, fv(2'h0, 7'h7F, 1'b0, 3'h0, 8'h00, 4'h0), mb, 0);
      issue(14'h0782, 3'h0, 6'h18, 6'h3F, fv(2'h0, 7'h02, 1'b1, 3'h0, 8'h00, 4'h0), mb, 0);
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         w = {6'h07, rnd[7], 7'(rnd[6:0] % 7'h7E + 7'h02)};
         issue(w, {1'b0, rnd[1:0]}, rnd[7] ? 6'h18 : 6'h14, 6'h3F,
               fv(2'h0, w[6:0], w[7], 3'h0, 8'h00, 4'h0), mb, 0);
      end
      $display("byte operations done");
      for (int b = 0; b < 8; b++) begin
         w = {4'h5, 3'(b), 7'h33};
         issue(w, 3'h0, 6'h18, 6'h3F, fv(2'h1, 7'h33, 1'b0, 3'(b), 8'h00, 4'h0), mt, 0);
      end
      $display("bit operations done");
      issue(14'h30A7, 3'h0, 6'h00, 6'h3F, fv(2'h2, 7'h00, 1'b0, 3'h0, 8'hA7, 4'h0), ml, 0);
      issue(14'h0060, 3'h0, 6'h00, 6'h3F, '0, '0, 0);
      $display("literal and ignored bits done");
      foreach (tc[i]) issue(tc[i], 3'h0, 6'h00, 6'h23, '0, '0, 1);
      for (int s = 0; s < 2; s++) begin
         foreach (sk[i]) issue(sk[i], {1'(s), 2'h0}, 6'h10, 6'h33, '0, '0, s);
      end
      $display("flow changes done");
      for (int j = 0; j < 8; j++) begin
         issue(14'h0010 | 14'(j), 3'h0, 6'h00, 6'h23,
               fv(2'h0, 7'h00, 1'b0, 3'h0, 8'h00, {1'b1, 3'(j)}), mp, 0);
      end
      $display("pointer operations done");
      issue(14'h0780, 3'h2, 6'h00, 6'h23, '0, '0, 2);
      issue(14'h0781, 3'h2, 6'h18, 6'h3F, '0, '0, 0);
      issue(14'h0781, 3'h1, 6'h00, 6'h23, '0, '0, 2);
      issue(NOP_WORD, 3'h0, 6'h00, 6'h3F, '0, '0, 0);
      issue(NOP_WORD, 3'h0, 6'h00, 6'h3F, '0, '0, 0);
      repeat (8) @(posedge i_clk);
      $display("indirect stalls done");
      check("queue", q.size(), 64'h0);
      finish_test();
   end
endmodule
